/* File: hdl/print_glue_map.vh */
/*
 * Constants for the print controller processor glue: memory map,
 * port offsets, reset values and timing figures.
 * Assumes inclusion by bare name from the design file and the checker.
 */
`ifndef PRINT_GLUE_MAP_VH
`define PRINT_GLUE_MAP_VH

// Upper address byte, bits 7:5 select the region
`define SEL_MSB          7
`define SEL_LSB          5
`define REGION_ROM       3'h0
`define REGION_RAM       3'h1
`define REGION_INPUT     3'h2
`define REGION_MOTOR     3'h3
`define REGION_LED       3'h4

// Decoder result codes
`define DEC_NONE         3'h0
`define DEC_ROM          3'h1
`define DEC_RAM          3'h2
`define DEC_INPUT        3'h3
`define DEC_MOTOR        3'h4
`define DEC_LED          3'h5

// Scratchpad size
`define RAM_AW           10
`define RAM_HIGH_BITS    2
`define RAM_GAP_MSB      4

// Port offsets inside a region (low address bits)
`define PORT_OFS_A       2'h0
`define PORT_OFS_B       2'h1
`define PORT_OFS_C       2'h2

// Reset values: every output line idle except inkEmptyFlag, which resets high
`define MOTOR_RESET      8'hFF
`define HOST_STAT_RESET  8'h3E
`define LED_RESET        8'h00
`define INPUT_RESET      8'hFF
`define INPUT_PAD        3'h7

// Host status byte field positions
`define HS_PAPER_JAM     0
`define HS_MACHINE_RDY   1
`define HS_DATA_RDY      2
`define HS_SIZE_MODE     3
`define HS_SKIP_PACK     4
`define HS_INK_EMPTY     5

// Timing
`define CLK_PERIOD_PS    8000
`define DOT_PERIOD_NS    50000
`define DOT_CYCLES       (`DOT_PERIOD_NS * 1000 / `CLK_PERIOD_PS)
// 4.4 MHz square wave: toggle rate 8.8 MHz as a fraction of 125 MHz
`define SYS_ACC_STEP     11'h058
`define SYS_ACC_MOD      11'h4E2

`endif

/* File: hdl/scratch_ram.v */
/*
 * Single-port scratchpad memory, synchronous write, registered read.
 * Assumes the caller holds the address stable for a cycle before reading.
 */
`timescale 1ns/1ps
module scratch_ram
#(
    parameter AW = 10,
    parameter DW = 8
)
(
    input  wire          mclk,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wrData,
    output reg  [DW-1:0] rdData
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge mclk)
    begin
        if (we)
            mem[addr] <= wrData;
        rdData <= mem[addr];
    end

endmodule

/* File: hdl/print_controller_cpu_glue.v */
/*
 * Glue around the print controller processor: low address latch, chip
 * select decode, scratchpad RAM, polled input port with status interrupt,
 * dot timing interrupt, motor/host status and LED output ports, and the
 * 4.4 MHz system timing square wave.
 * Assumes all inputs are synchronous to mclk and the processor strobes
 * last at least two mclk cycles.
 */
`timescale 1ns/1ps
`include "print_glue_map.vh"

module print_controller_cpu_glue
#(
    parameter DOT_CYCLES = `DOT_CYCLES
)
(
    input  wire       mclk,
    input  wire       rstn,
    input  wire [7:0] muxedAddrDataIn,
    output reg  [7:0] muxedAddrDataOut,
    output wire       muxedAddrDataOe,
    input  wire [7:0] addrHigh,
    input  wire       ale,
    input  wire       readN,
    input  wire       writeN,
    output wire [7:0] latchedLowAddress,
    output wire       romCeN,
    output wire       ramCeN,
    output wire       inputCeN,
    output wire       motorCeN,
    output wire       ledCeN,
    input  wire       hostInterruptRequestN,
    input  wire       carriageRightLimitN,
    input  wire       printRequestN,
    input  wire       carriageEnableInN,
    input  wire [7:0] sensorIn,
    output wire       statusInterrupt,
    output reg        dotInterrupt,
    output reg        dotClockPulseN,
    output reg        sysClock,
    output wire [7:0] motorCtrl,
    output wire       paperJamFlag,
    output wire       machineReadyN,
    output wire       printDataReadyN,
    output wire       sizeModeN,
    output wire       skipPackN,
    output wire       inkEmptyFlag,
    output wire [7:0] ledCtrl
);

    localparam DW = 13;

    function [2:0] decodeRegion;
        input [7:0] hi;
        begin
            case (hi[`SEL_MSB:`SEL_LSB])
                `REGION_ROM:   decodeRegion = `DEC_ROM;
                `REGION_RAM:   decodeRegion =
                               (hi[`RAM_GAP_MSB:`RAM_HIGH_BITS] == 3'h0)
                                              ? `DEC_RAM : `DEC_NONE;
                `REGION_INPUT: decodeRegion = `DEC_INPUT;
                `REGION_MOTOR: decodeRegion = `DEC_MOTOR;
                `REGION_LED:   decodeRegion = `DEC_LED;
                default:       decodeRegion = `DEC_NONE;
            endcase
        end
    endfunction

    reg  [7:0]    lowAddr_q;
    reg  [7:0]    wrData_q;
    reg           writeN_q;
    reg  [7:0]    motor_q;
    reg  [7:0]    hostStat_q;
    reg  [7:0]    led_q;
    reg  [7:0]    inputA_q;
    reg  [7:0]    inputB_q;
    reg  [DW-1:0] dotCnt_q;
    reg  [10:0]   sysAcc_q;
    reg  [7:0]    portRd_d;

    wire [2:0]    region;
    wire          strobe;
    wire          writeDone;
    wire [7:0]    ramRdData;
    wire [10:0]   sysSum;

    // Latch follows the bus only while the strobe is high
    always @(posedge mclk)
    begin
        if (!rstn)
            lowAddr_q <= 8'h00;
        else if (ale)
            lowAddr_q <= muxedAddrDataIn;
    end
    assign latchedLowAddress = lowAddr_q;

    // Enables ignore the bus while neither strobe is low, so a
    // dangling address never selects anything
    assign region   = decodeRegion(addrHigh);
    assign strobe   = !readN || !writeN;
    assign romCeN   = !(strobe && region == `DEC_ROM);
    assign ramCeN   = !(strobe && region == `DEC_RAM);
    assign inputCeN = !(strobe && region == `DEC_INPUT);
    assign motorCeN = !(strobe && region == `DEC_MOTOR);
    assign ledCeN   = !(strobe && region == `DEC_LED);

    // Write data is held while the strobe is low and committed at its
    // rising edge, once per strobe, when the processor's data is settled
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            writeN_q <= 1'b1;
            wrData_q <= 8'h00;
        end
        else
        begin
            writeN_q <= writeN;
            if (!writeN)
                wrData_q <= muxedAddrDataIn;
        end
    end
    assign writeDone = !writeN_q && writeN;

    scratch_ram
    #(
        .AW (`RAM_AW),
        .DW (8)
    )
    uRam
    (
        .mclk   (mclk),
        .we     (writeDone && region == `DEC_RAM),
        .addr   ({addrHigh[`RAM_HIGH_BITS-1:0], lowAddr_q}),
        .wrData (wrData_q),
        .rdData (ramRdData)
    );

    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            motor_q    <= `MOTOR_RESET;
            hostStat_q <= `HOST_STAT_RESET;
            led_q      <= `LED_RESET;
        end
        else if (writeDone)
        begin
            if (region == `DEC_MOTOR && lowAddr_q[1:0] == `PORT_OFS_A)
                motor_q <= wrData_q;
            if (region == `DEC_MOTOR && lowAddr_q[1:0] == `PORT_OFS_B)
                hostStat_q <= wrData_q;
            if (region == `DEC_LED)
                led_q <= wrData_q;
        end
    end
    assign motorCtrl       = motor_q;
    assign paperJamFlag    = hostStat_q[`HS_PAPER_JAM];
    assign machineReadyN   = hostStat_q[`HS_MACHINE_RDY];
    assign printDataReadyN = hostStat_q[`HS_DATA_RDY];
    assign sizeModeN       = hostStat_q[`HS_SIZE_MODE];
    assign skipPackN       = hostStat_q[`HS_SKIP_PACK];
    assign inkEmptyFlag    = hostStat_q[`HS_INK_EMPTY];
    assign ledCtrl         = led_q;

    // Input lines registered so a poll sees one coherent snapshot
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            inputA_q <= `INPUT_RESET;
            inputB_q <= `INPUT_RESET;
        end
        else
        begin
            inputA_q <= {`INPUT_PAD, dotClockPulseN, carriageEnableInN,
                         printRequestN, carriageRightLimitN,
                         hostInterruptRequestN};
            inputB_q <= sensorIn;
        end
    end

    // Level interrupt: stays up until the cause goes away, the
    // processor reads the port to tell the two apart
    assign statusInterrupt = !inputA_q[0] || !inputA_q[1];

    always @*
    begin
        case (lowAddr_q[1:0])
            `PORT_OFS_A: portRd_d = inputA_q;
            `PORT_OFS_B: portRd_d = inputB_q;
            `PORT_OFS_C: portRd_d = hostStat_q;
            default:     portRd_d = 8'h00;
        endcase
    end

    // Read data is registered; RAM adds its own cycle, so strobes
    // shorter than two cycles return stale data
    always @(posedge mclk)
    begin
        if (!rstn)
            muxedAddrDataOut <= 8'h00;
        else if (region == `DEC_RAM)
            muxedAddrDataOut <= ramRdData;
        else
            muxedAddrDataOut <= portRd_d;
    end
    // Bus only driven in the data phase of a local read
    assign muxedAddrDataOe = !readN && !ale &&
                             (region == `DEC_RAM || region == `DEC_INPUT);

    // Dot clock: low for the first half of each period
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            dotCnt_q       <= {DW{1'b0}};
            dotClockPulseN <= 1'b1;
            dotInterrupt   <= 1'b0;
        end
        else
        begin
            if (dotCnt_q == DOT_CYCLES[DW-1:0] - 1'b1)
                dotCnt_q <= {DW{1'b0}};
            else
                dotCnt_q <= dotCnt_q + 1'b1;
            dotClockPulseN <= !(dotCnt_q < DOT_CYCLES[DW:1]);
            dotInterrupt   <= (dotCnt_q == {DW{1'b0}});
        end
    end

    // Fractional divider: 4.4 MHz cannot divide 125 MHz evenly, so
    // edges jitter by one mclk period but average out exactly
    assign sysSum = sysAcc_q + `SYS_ACC_STEP;
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            sysAcc_q <= 11'h000;
            sysClock <= 1'b0;
        end
        else if (sysSum >= `SYS_ACC_MOD)
        begin
            sysAcc_q <= sysSum - `SYS_ACC_MOD;
            sysClock <= !sysClock;
        end
        else
            sysAcc_q <= sysSum;
    end

endmodule

/* File: dv/print_glue_props.sv */
/* Port checker for the processor glue.
   Assumes it is bound to the glue top and sees only its ports. */
`timescale 1ns/1ps
`include "print_glue_map.vh"
module print_glue_props
#(
    parameter DOT_CYCLES = 20
)
(
    input wire       mclk,
    input wire       rstn,
    input wire [7:0] muxedAddrDataIn,
    input wire       muxedAddrDataOe,
    input wire       ale,
    input wire       readN,
    input wire       writeN,
    input wire [7:0] addrHigh,
    input wire [7:0] latchedLowAddress,
    input wire       romCeN,
    input wire       ramCeN,
    input wire       inputCeN,
    input wire       motorCeN,
    input wire       ledCeN,
    input wire       hostInterruptRequestN,
    input wire       carriageRightLimitN,
    input wire       statusInterrupt,
    input wire       dotInterrupt,
    input wire       dotClockPulseN,
    input wire [7:0] motorCtrl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire  [4:0] ce = ~{romCeN, ramCeN, inputCeN, motorCeN, ledCeN};
    int         gap_q;
    logic       seen_q;
    // First pulse after reset has no reference, so the gap starts there
    always @(posedge mclk)
    begin
        gap_q  <= (!rstn || dotInterrupt) ? 0 : gap_q + 1;
        seen_q <= rstn && (seen_q || dotInterrupt);
    end
    sequence motorCommit;
        !writeN && addrHigh[7:5] == `REGION_MOTOR &&
        latchedLowAddress[1:0] == `PORT_OFS_A ##1 writeN;
    endsequence
    chk_latch_capture: assert property (ale |=>
        latchedLowAddress == $past(muxedAddrDataIn)) else $error("latch");
    chk_latch_hold: assert property (!ale |=>
        $stable(latchedLowAddress)) else $error("latch moved");
    chk_one_enable: assert property ($onehot0(ce))
        else $error("two enables");
    chk_idle_no_enable: assert property (readN && writeN |->
        ce == 5'h00) else $error("idle enable");
    chk_decode_motor: assert property (!writeN &&
        addrHigh[7:5] == `REGION_MOTOR |-> !motorCeN)
        else $error("motor enable");
    chk_input_drive: assert property (!readN && !ale &&
        addrHigh[7:5] == `REGION_INPUT |-> muxedAddrDataOe)
        else $error("bus drive");
    chk_status_irq: assert property ($past(rstn) |-> statusInterrupt ==
        !$past(hostInterruptRequestN && carriageRightLimitN))
        else $error("status irq");
    chk_dot_edge: assert property ($past(rstn) |->
        dotInterrupt == $fell(dotClockPulseN)) else $error("dot edge");
    chk_dot_period: assert property (seen_q |->
        dotInterrupt == (gap_q == DOT_CYCLES - 1)) else $error("dot gap");
    chk_motor_write: assert property (motorCommit |=>
        motorCtrl == $past(muxedAddrDataIn, 2)) else $error("motor");
endmodule
bind print_controller_cpu_glue print_glue_props
    #(.DOT_CYCLES(DOT_CYCLES)) print_glue_props_i (
    .mclk                  (mclk),
    .rstn                  (rstn),
    .muxedAddrDataIn       (muxedAddrDataIn),
    .muxedAddrDataOe       (muxedAddrDataOe),
    .ale                   (ale),
    .readN                 (readN),
    .writeN                (writeN),
    .addrHigh              (addrHigh),
    .latchedLowAddress     (latchedLowAddress),
    .romCeN                (romCeN),
    .ramCeN                (ramCeN),
    .inputCeN              (inputCeN),
    .motorCeN              (motorCeN),
    .ledCeN                (ledCeN),
    .hostInterruptRequestN (hostInterruptRequestN),
    .carriageRightLimitN   (carriageRightLimitN),
    .statusInterrupt       (statusInterrupt),
    .dotInterrupt          (dotInterrupt),
    .dotClockPulseN        (dotClockPulseN),
    .motorCtrl             (motorCtrl)
);

/* File: dv/cpu_bus_model.sv */
/* Processor bus model: address phase, then a data strobe.
   Assumes its tasks are called from the mclk domain. */
`timescale 1ns/1ps
module cpu_bus_model
(
    input  wire        mclk,
    input  wire  [7:0] rdBus,
    output logic [7:0] wrBus,
    output logic [7:0] addrHigh,
    output logic       ale,
    output logic       readN,
    output logic       writeN
);
    initial
    begin
        {wrBus, addrHigh, ale, readN, writeN} = 19'h00003;
    end
    // Address alone under the strobe, data only afterwards
    task automatic addr(input [7:0] hi, input [7:0] lo);
    begin
        @(posedge mclk);
        ale      <= 1'b1;
        addrHigh <= hi;
        wrBus    <= lo;
        @(posedge mclk);
        ale      <= 1'b0;
    end
    endtask
    task automatic wr(input [7:0] hi, input [7:0] lo, input [7:0] d);
    begin
        addr(hi, lo);
        wrBus  <= d;
        writeN <= 1'b0;
        repeat (2) @(posedge mclk);
        writeN <= 1'b1;
        @(posedge mclk);
        // No pull on the bus: a stale byte must not pass for data
        wrBus  <= ~d;
    end
    endtask
    task automatic rd(input [7:0] hi, input [7:0] lo, output [7:0] d);
    begin
        addr(hi, lo);
        wrBus <= ~lo;
        readN <= 1'b0;
        repeat (3) @(posedge mclk);
        d = rdBus;
        readN <= 1'b1;
    end
    endtask
endmodule

/* File: dv/test_print_controller_cpu_glue.sv */
/* Self-checking bench for the processor glue.
   Assumes the bus model stands in for the processor. */
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
    err_total++; $display("[FAIL] %s exp %h seen %h", n, e, a); end end
module test_print_controller_cpu_glue;
    localparam DOTN = 20;
    logic       mclk, rstn, hostIrqN, limitN, prtReqN, carEnN;
    logic [7:0] sensor, rdata;
    wire  [7:0] busIn, busOut, hi, latch, motor, led;
    wire        ale, readN, writeN, oe, sIrq, dIrq, dClkN, sysClk;
    wire  [4:0] ceN;
    wire  [5:0] hs;
    int         err_total, cmp_count;
    cpu_bus_model cpu_bus_model_i (.mclk(mclk), .rdBus(busOut),
        .wrBus(busIn), .addrHigh(hi), .ale(ale), .readN(readN),
        .writeN(writeN));
    print_controller_cpu_glue #(.DOT_CYCLES(DOTN))
    print_controller_cpu_glue_i (.mclk(mclk), .rstn(rstn),
        .muxedAddrDataIn(busIn), .muxedAddrDataOut(busOut),
        .muxedAddrDataOe(oe), .addrHigh(hi), .ale(ale), .readN(readN),
        .writeN(writeN), .latchedLowAddress(latch), .romCeN(ceN[4]),
        .ramCeN(ceN[3]), .inputCeN(ceN[2]), .motorCeN(ceN[1]),
        .ledCeN(ceN[0]), .hostInterruptRequestN(hostIrqN),
        .carriageRightLimitN(limitN), .printRequestN(prtReqN),
        .carriageEnableInN(carEnN), .sensorIn(sensor),
        .statusInterrupt(sIrq), .dotInterrupt(dIrq),
        .dotClockPulseN(dClkN), .sysClock(sysClk), .motorCtrl(motor),
        .paperJamFlag(hs[0]), .machineReadyN(hs[1]),
        .printDataReadyN(hs[2]), .sizeModeN(hs[3]), .skipPackN(hs[4]),
        .inkEmptyFlag(hs[5]), .ledCtrl(led));
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task give_verdict;
    begin
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task t_ports;
    begin
        `CHK("rstMotor", 8'hFF, motor)
        `CHK("rstHost", 6'h3E, hs)
        cpu_bus_model_i.wr(8'h60, 8'h00, 8'h5A);
        cpu_bus_model_i.wr(8'h60, 8'h00, 8'hA5);
        @(negedge mclk);
        `CHK("motor", 8'hA5, motor)
        cpu_bus_model_i.wr(8'h60, 8'h01, 8'h15);
        cpu_bus_model_i.wr(8'h00, 8'h00, 8'h33);
        cpu_bus_model_i.wr(8'h80, 8'h02, 8'hC3);
        @(negedge mclk);
        `CHK("latch", 8'h02, latch)
        `CHK("host", 6'h15, hs)
        `CHK("romWr", 8'hA5, motor)
        `CHK("led", 8'hC3, led)
        $display("ports done");
    end
    endtask
    task t_ram;
    begin
        cpu_bus_model_i.wr(8'h23, 8'h7E, 8'h96);
        cpu_bus_model_i.wr(8'h22, 8'h7E, 8'h69);
        cpu_bus_model_i.rd(8'h23, 8'h7E, rdata);
        `CHK("ramA", 8'h96, rdata)
        cpu_bus_model_i.rd(8'h22, 8'h7E, rdata);
        `CHK("ramB", 8'h69, rdata)
        $display("ram done");
    end
    endtask
    task t_irq;
    begin
        @(posedge mclk);
        hostIrqN <= 1'b0;
        prtReqN  <= 1'b0;
        repeat (2) @(negedge mclk);
        `CHK("irqHost", 1'b1, sIrq)
        @(posedge mclk);
        hostIrqN <= 1'b1;
        limitN   <= 1'b0;
        carEnN   <= 1'b0;
        cpu_bus_model_i.rd(8'h40, 8'h00, rdata);
        @(negedge mclk);
        `CHK("inPort", 8'hE1, rdata & 8'hEF)
        `CHK("irqLimit", 1'b1, sIrq)
        @(posedge mclk);
        limitN <= 1'b1;
        carEnN <= 1'b1;
        sensor <= 8'hC4;
        repeat (2) @(negedge mclk);
        `CHK("irqIdle", 1'b0, sIrq)
        cpu_bus_model_i.rd(8'h40, 8'h01, rdata);
        `CHK("sensor", 8'hC4, rdata)
        cpu_bus_model_i.rd(8'h40, 8'h02, rdata);
        `CHK("hostBack", 8'h15, rdata)
        $display("irq done");
    end
    endtask
    task t_timing;
        int n;
        logic p;
    begin
        repeat (100) if (dIrq !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        for (n = 1; dIrq !== 1'b1 && n < 100; n++) @(negedge mclk);
        `CHK("dotGap", DOTN, n)
        `CHK("dotEdge", 1'b0, dClkN)
        n = 0;
        p = sysClk;
        repeat (1250)
        begin
            @(negedge mclk);
            n += (sysClk !== p);
            p = sysClk;
        end
        // 10 us at 4.4 MHz is 88 toggles, allowing one of jitter
        `CHK("sysClk", 1'b1, n >= 87 && n <= 89)
        $display("timing done");
    end
    endtask
    initial
    begin
        rstn     = 1'b0;
        hostIrqN = 1'b1;
        limitN   = 1'b1;
        prtReqN  = 1'b1;
        carEnN   = 1'b1;
        sensor   = 8'h00;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        t_ports;
        t_ram;
        t_irq;
        t_timing;
        give_verdict;
    end
    // Whole run needs about 1400 cycles; fourteen times that means a hang
    initial
    begin
        #160000;
        err_total++;
        give_verdict;
    end
endmodule
